/* File: sfps_seq.sv */
`timescale 1ns/100ps
`include "sfps_cfg.svh"
// Notes on behaviour
// - dual/quad output reads take address on si
// - instruction picks phase after single input
// - latency cycles counted from latency code
// - inputs ignored during latency cycles
// - all io undriven during latency
// - single output drives so, ignores si
// - output phases stream until cs rises
// - dual io read: two bits per clock
// - dual output drives io0 and io1
// - dual latency ends in dual output
// - quad program/read: address on io0 only
// - quad program to quad input, read to latency (straight to quad output for code 3)
// - quad input captures four bits per clock
// - quad io read: latency then quad output (no latency for code 3)
// - quad output drives io0 to io3
// - ddr fast read: io0, both edges, latency
// - ddr dual read: io0/io1, both edges
// - instruction eight bits msb first, rising
// - quad enable permits quad commands
// - latency code sets mode and latency cycles
module sfps_seq (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                nrst,
    // spi pins, sampled on mclk
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic [3:0]          io_in,
    output logic      [3:0]          io_out_ff,
    output logic      [3:0]          io_oe_ff,
    // configuration_register bits
    input  wire logic [1:0]          cfg_latency_code,
    input  wire logic                cfg_quad_en,
    // user side
    input  wire logic [7:0]          rd_data,
    output logic                     rd_take_ff,
    output logic      [31:0]         hdr_ff,
    output logic      [7:0]          prog_byte_ff,
    output logic                     prog_vld_ff,
    output sfps_pkg::sfps_state_t    state_ff
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [5:0] lat_of(input logic [1:0] code);
        case (code)
            2'h0:    lat_of = `SFPS_LAT_C0;
            2'h1:    lat_of = `SFPS_LAT_C1;
            2'h2:    lat_of = `SFPS_LAT_C2;
            default: lat_of = `SFPS_LAT_C3;
        endcase
    endfunction

    function automatic logic [5:0] mode_of(input logic [1:0] code, input logic [5:0] m);
        mode_of = (code == `SFPS_NOMODE_CODE) ? 6'h00 : m;
    endfunction

    function automatic sfps_pkg::sfps_plan_t dec(input logic [7:0] op,
                                                 input logic [1:0] code,
                                                 input logic       qen);
        sfps_pkg::sfps_plan_t p;
        logic [5:0]           lat;
        lat = lat_of(code);
        p   = '{sfps_pkg::ST_WAIT, 6'h00, sfps_pkg::ST_WAIT, 6'h00};
        case (op)
            `SFPS_OP_READ: p = '{sfps_pkg::ST_SIN, `SFPS_SIN_ADDR, sfps_pkg::ST_SOUT, 6'h00};
            `SFPS_OP_FAST: p = '{sfps_pkg::ST_SIN, `SFPS_SIN_ADDR, sfps_pkg::ST_SOUT, lat};
            `SFPS_OP_DOR:  p = '{sfps_pkg::ST_SIN, `SFPS_SIN_ADDR, sfps_pkg::ST_DOUT, lat};
            `SFPS_OP_QUAD_OUTPUT_READ: begin
                if (qen)
                    p = '{sfps_pkg::ST_SIN, `SFPS_SIN_ADDR, sfps_pkg::ST_QOUT, lat};
            end
            `SFPS_OP_QUAD_PAGE_PROGRAM: begin
                if (qen)
                    p = '{sfps_pkg::ST_SIN, `SFPS_SIN_ADDR, sfps_pkg::ST_QIN, 6'h00};
            end
            `SFPS_OP_DIOR: p = '{sfps_pkg::ST_DIN,
                                 6'(`SFPS_DIN_ADDR + mode_of(code, `SFPS_DIN_MODE)),
                                 sfps_pkg::ST_DOUT, lat};
            `SFPS_OP_QIOR: begin
                if (qen)
                    p = '{sfps_pkg::ST_QIN,
                          6'(`SFPS_QIN_ADDR + mode_of(code, `SFPS_QIN_MODE)),
                          sfps_pkg::ST_QOUT, lat};
            end
            `SFPS_OP_DDRF: p = '{sfps_pkg::ST_DDR1,
                                 6'(`SFPS_DDR1_ADDR + mode_of(code, `SFPS_DDR1_MODE)),
                                 sfps_pkg::ST_DDRLAT, 6'h00};
            `SFPS_OP_DDRD: p = '{sfps_pkg::ST_DDR2,
                                 6'(`SFPS_DDR2_ADDR + mode_of(code, `SFPS_DDR2_MODE)),
                                 sfps_pkg::ST_DDRLAT, 6'h00};
            default: p = p;
        endcase
        return p;
    endfunction

    // ----------------------------------------------------------------
    // sck edges
    // ----------------------------------------------------------------
    logic                  sck_prev_ff;
    logic                  rise;
    logic                  fall;
    logic                  is_ddr;
    logic                  is_in;
    logic                  ev;
    logic [5:0]            cnt_ff;
    logic [5:0]            lat_ff;
    sfps_pkg::sfps_state_t after_ff;
    sfps_pkg::sfps_plan_t  plan;
    logic [7:0]            op_now;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            sck_prev_ff <= 1'b0;
        else
            sck_prev_ff <= sck;
    end

    assign rise   = sck & ~sck_prev_ff;
    assign fall   = ~sck & sck_prev_ff;
    assign is_ddr = (state_ff == sfps_pkg::ST_DDR1) || (state_ff == sfps_pkg::ST_DDR2);
    assign is_in  = is_ddr || (state_ff == sfps_pkg::ST_INSTR) || (state_ff == sfps_pkg::ST_SIN)
                    || (state_ff == sfps_pkg::ST_DIN) || (state_ff == sfps_pkg::ST_QIN);
    assign ev     = is_ddr ? (rise | fall) : rise;
    assign op_now = {hdr_ff[6:0], io_in[0]};
    assign plan   = dec(op_now, cfg_latency_code, cfg_quad_en);

    // ----------------------------------------------------------------
    // phase sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= sfps_pkg::ST_IDLE;
            cnt_ff   <= 6'h00;
            lat_ff   <= 6'h00;
            after_ff <= sfps_pkg::ST_IDLE;
        end else if (cs_n) begin
            state_ff <= sfps_pkg::ST_IDLE;
            cnt_ff   <= 6'h00;
        end else begin
            case (state_ff)
                sfps_pkg::ST_IDLE: begin
                    state_ff <= sfps_pkg::ST_INSTR;
                    cnt_ff   <= `SFPS_INSTR_BITS;
                end
                sfps_pkg::ST_INSTR: begin
                    if (rise) begin
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            state_ff <= plan.first;
                            cnt_ff   <= plan.cnt;
                            after_ff <= plan.after;
                            lat_ff   <= plan.lat;
                        end
                    end
                end
                sfps_pkg::ST_SIN, sfps_pkg::ST_DIN, sfps_pkg::ST_QIN,
                sfps_pkg::ST_DDR1, sfps_pkg::ST_DDR2: begin
                    // a count of zero marks a streaming input, program data
                    if (ev && cnt_ff != 6'h00) begin
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            cnt_ff   <= lat_ff;
                            state_ff <= (lat_ff != 6'h00) ? sfps_pkg::ST_LAT : after_ff;
                        end
                    end
                end
                sfps_pkg::ST_LAT: begin
                    if (rise) begin
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01)
                            state_ff <= after_ff;
                    end
                end
                sfps_pkg::ST_SOUT, sfps_pkg::ST_DOUT, sfps_pkg::ST_QOUT,
                sfps_pkg::ST_DDRLAT, sfps_pkg::ST_WAIT: state_ff <= state_ff;
                default: state_ff <= sfps_pkg::ST_WAIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // input capture; io lines not named by the phase are ignored
    // ----------------------------------------------------------------
    logic half_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hdr_ff <= 32'h0000_0000;
        end else if (cs_n) begin
            hdr_ff <= 32'h0000_0000;
        end else if (is_in && ev) begin
            case (state_ff)
                sfps_pkg::ST_DIN, sfps_pkg::ST_DDR2:
                    hdr_ff <= {hdr_ff[29:0], io_in[1:0]};
                sfps_pkg::ST_QIN:
                    hdr_ff <= {hdr_ff[27:0], io_in};
                default:
                    hdr_ff <= {hdr_ff[30:0], io_in[0]};
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            half_ff      <= 1'b0;
            prog_vld_ff  <= 1'b0;
            prog_byte_ff <= 8'h00;
        end else begin
            prog_vld_ff <= 1'b0;
            if (cs_n) begin
                half_ff <= 1'b0;
            end else if (state_ff == sfps_pkg::ST_QIN && cnt_ff == 6'h00 && rise) begin
                half_ff <= ~half_ff;
                if (half_ff) begin
                    prog_byte_ff <= {hdr_ff[3:0], io_in};
                    prog_vld_ff  <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output launch on falling sck
    // ----------------------------------------------------------------
    logic [7:0] osh_ff;
    logic [2:0] oc_ff;
    logic       is_out;
    logic [7:0] cur;

    assign is_out = (state_ff == sfps_pkg::ST_SOUT) || (state_ff == sfps_pkg::ST_DOUT)
                    || (state_ff == sfps_pkg::ST_QOUT);
    assign cur    = (oc_ff == 3'h0) ? rd_data : osh_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_out_ff  <= 4'h0;
            io_oe_ff   <= `SFPS_OE_NONE;
            osh_ff     <= 8'h00;
            oc_ff      <= 3'h0;
            rd_take_ff <= 1'b0;
        end else begin
            rd_take_ff <= 1'b0;
            if (cs_n || !is_out) begin
                // latency and input phases leave every line undriven
                // drive values drop too, so no stale data waits behind the enables
                io_out_ff <= 4'h0;
                io_oe_ff  <= `SFPS_OE_NONE;
                oc_ff     <= 3'h0;
            end else if (fall) begin
                rd_take_ff <= (oc_ff == 3'h0);
                case (state_ff)
                    sfps_pkg::ST_QOUT: begin
                        io_out_ff <= cur[7:4];
                        io_oe_ff  <= `SFPS_OE_QUAD;
                        osh_ff    <= {cur[3:0], 4'h0};
                        oc_ff     <= (oc_ff == 3'h0) ? 3'h1 : oc_ff - 3'h1;
                    end
                    sfps_pkg::ST_DOUT: begin
                        io_out_ff <= {2'b00, cur[7:6]};
                        io_oe_ff  <= `SFPS_OE_DUAL;
                        osh_ff    <= {cur[5:0], 2'b00};
                        oc_ff     <= (oc_ff == 3'h0) ? 3'h3 : oc_ff - 3'h1;
                    end
                    default: begin
                        io_out_ff <= {2'b00, cur[7], 1'b0};
                        io_oe_ff  <= `SFPS_OE_SINGLE;
                        osh_ff    <= {cur[6:0], 1'b0};
                        oc_ff     <= (oc_ff == 3'h0) ? 3'h7 : oc_ff - 3'h1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_last_rise(sfps_pkg::sfps_state_t st);
        state_ff == st && rise && cnt_ff == 6'h01;
    endsequence

    sequence s_out_fall(sfps_pkg::sfps_state_t st);
        state_ff == st && !cs_n && fall;
    endsequence

    a_lat_hiz: assert property (state_ff == sfps_pkg::ST_LAT ##1 !cs_n |-> io_oe_ff == 4'h0)
        else $error("io driven during latency");
    a_cs_ends: assert property (cs_n |=> state_ff == sfps_pkg::ST_IDLE ##1 io_oe_ff == 4'h0)
        else $error("cs high did not end command");
    a_sout_so: assert property (s_out_fall(sfps_pkg::ST_SOUT) |=> io_oe_ff == 4'h2)
        else $error("single output not on so");
    a_dout_two: assert property (s_out_fall(sfps_pkg::ST_DOUT) |=> io_oe_ff == 4'h3)
        else $error("dual output lines wrong");
    a_qout_four: assert property (s_out_fall(sfps_pkg::ST_QOUT) |=> io_oe_ff == 4'hf)
        else $error("quad output lines wrong");
    a_lat_exit: assert property (s_last_rise(sfps_pkg::ST_LAT) ##1 !cs_n
        |-> state_ff == $past(after_ff) && state_ff != sfps_pkg::ST_LAT)
        else $error("latency did not end in output");
    a_instr_len: assert property (state_ff == sfps_pkg::ST_IDLE && !cs_n
        |=> state_ff == sfps_pkg::ST_INSTR && cnt_ff == 6'h08)
        else $error("instruction count wrong");
    a_addr_next: assert property (s_last_rise(sfps_pkg::ST_SIN) ##1 !cs_n
        |-> state_ff == (($past(lat_ff) != 6'h00) ? sfps_pkg::ST_LAT : $past(after_ff)))
        else $error("address phase exit wrong");
    a_ddr_next: assert property (state_ff == sfps_pkg::ST_DDR1 && (rise || fall)
        && cnt_ff == 6'h01 ##1 !cs_n |-> state_ff == sfps_pkg::ST_DDRLAT)
        else $error("ddr input did not reach latency");
    a_quad_gate: assert property (state_ff == sfps_pkg::ST_INSTR
        && rise && cnt_ff == 6'h01 && !cfg_quad_en
        && (op_now == `SFPS_OP_QUAD_PAGE_PROGRAM || op_now == `SFPS_OP_QUAD_OUTPUT_READ
        || op_now == `SFPS_OP_QIOR)
        |=> cs_n || state_ff == sfps_pkg::ST_WAIT)
        else $error("quad command accepted without quad enable");

endmodule

/* File: sfps_cfg.svh */
`ifndef SFPS_CFG_SVH
`define SFPS_CFG_SVH

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SFPS_OP_READ      8'h03
`define SFPS_OP_FAST      8'h0b
`define SFPS_OP_DOR       8'h3b
`define SFPS_OP_QUAD_OUTPUT_READ  8'h6b
`define SFPS_OP_DIOR      8'hbb
`define SFPS_OP_QIOR      8'heb
`define SFPS_OP_QUAD_PAGE_PROGRAM 8'h32
`define SFPS_OP_DDRF      8'h0d
`define SFPS_OP_DDRD      8'hbd

// ----------------------------------------------------------------
// phase lengths (sck cycles, or sck edges for ddr phases)
// ----------------------------------------------------------------
`define SFPS_INSTR_BITS   6'h08
`define SFPS_SIN_ADDR     6'h18
`define SFPS_DIN_ADDR     6'h0c
`define SFPS_DIN_MODE     6'h04
`define SFPS_QIN_ADDR     6'h06
`define SFPS_QIN_MODE     6'h02
`define SFPS_DDR1_ADDR    6'h18
`define SFPS_DDR1_MODE    6'h08
`define SFPS_DDR2_ADDR    6'h0c
`define SFPS_DDR2_MODE    6'h04

// ----------------------------------------------------------------
// latency code table, configuration_register bits 7:6
// ----------------------------------------------------------------
`define SFPS_LAT_C0       6'h08
`define SFPS_LAT_C1       6'h06
`define SFPS_LAT_C2       6'h04
`define SFPS_LAT_C3       6'h00
`define SFPS_NOMODE_CODE  2'h3

// ----------------------------------------------------------------
// output enable patterns, bit n drives io line n
// ----------------------------------------------------------------
`define SFPS_OE_SINGLE    4'h2
`define SFPS_OE_DUAL      4'h3
`define SFPS_OE_QUAD      4'hf
`define SFPS_OE_NONE      4'h0

`endif

/* File: sfps_pkg.sv */
package sfps_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_INSTR, ST_SIN, ST_DIN, ST_QIN, ST_DDR1, ST_DDR2,
        ST_LAT, ST_SOUT, ST_DOUT, ST_QOUT, ST_DDRLAT, ST_WAIT
    } sfps_state_t;

    typedef struct packed {
        sfps_state_t first;
        logic [5:0]  cnt;
        sfps_state_t after;
        logic [5:0]  lat;
    } sfps_plan_t;

endpackage

/* File: sfps_host.sv */
`timescale 1ns/100ps
module sfps_host (
    // clock
    input  wire logic       mclk,
    // resolved io lines
    input  wire logic [3:0] io_bus,
    // host pins
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] host_val,
    output logic      [3:0] host_oe
);
    initial begin
        cs_n     = 1'b1;
        sck      = 1'b0;
        host_val = 4'h0;
        host_oe  = 4'h0;
    end

    // ----------------------------------------------------------------
    // sdr clock: data moves with the fall, io read just before the rise
    // ----------------------------------------------------------------
    task cyc(input logic [3:0] drv, input logic [3:0] oe, output logic [3:0] smp);
        @(posedge mclk);
        sck      <= 1'b0;
        host_val <= drv;
        host_oe  <= oe;
        @(posedge mclk);
        @(posedge mclk);
        smp = io_bus;
        sck <= 1'b1;
        @(posedge mclk);
    endtask

    // unused lanes carry junk that the device has to ignore
    task send(input int w, input int n, input logic [39:0] v);
        logic [3:0] d;
        logic [3:0] s;
        for (int i = 0; i < n; i++) begin
            d = (w == 1) ? {3'h5, v[39]} : (w == 2) ? {2'h2, v[39:38]} : v[39:36];
            cyc(d, 4'hf, s);
            v = v << w;
        end
    endtask

    // one ddr edge per pass: data settles a cycle before sck turns
    task ddr(input int w, input int n, input logic [31:0] v);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            host_val <= (w == 1) ? {3'h6, v[31]} : {2'h1, v[31:30]};
            host_oe  <= 4'hf;
            @(posedge mclk);
            sck <= ~sck;
            @(posedge mclk);
            v = v << w;
        end
    endtask

    task start();
        @(posedge mclk);
        sck  <= 1'b0;
        cs_n <= 1'b0;
    endtask

    task stop();
        @(posedge mclk);
        sck     <= 1'b0;
        host_oe <= 4'h0;
        @(posedge mclk);
        cs_n <= 1'b1;
    endtask
endmodule

/* File: sfps_seq_tb_top.sv */
`timescale 1ns/100ps
`include "sfps_cfg.svh"
module sfps_seq_tb_top;
    typedef struct {
        logic [7:0]            op;
        int                    in_w;
        int                    mode_clk;
        int                    out_w;
        logic                  has_lat;
        sfps_pkg::sfps_state_t st;
        logic [3:0]            oe;
    } sfps_row_t;

    logic                  mclk;
    logic                  nrst;
    logic                  cs_n;
    logic                  sck;
    logic [3:0]            host_val;
    logic [3:0]            host_oe;
    logic [3:0]            io_bus;
    logic [3:0]            io_out_ff;
    logic [3:0]            io_oe_ff;
    logic [1:0]            cfg_latency_code;
    logic                  cfg_quad_en;
    logic [7:0]            rd_data;
    logic                  rd_take_ff;
    logic [31:0]           hdr_ff;
    logic [7:0]            prog_byte_ff;
    logic                  prog_vld_ff;
    sfps_pkg::sfps_state_t state_ff;
    logic                  flt;
    int                    errors;
    int                    samples_checked;
    int                    cycles;
    logic [7:0]            progq[$];
    sfps_row_t             rows[6];

    sfps_seq DUT (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .io_in(io_bus),
        .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff), .cfg_latency_code(cfg_latency_code),
        .cfg_quad_en(cfg_quad_en), .rd_data(rd_data), .rd_take_ff(rd_take_ff),
        .hdr_ff(hdr_ff), .prog_byte_ff(prog_byte_ff), .prog_vld_ff(prog_vld_ff),
        .state_ff(state_ff));
    sfps_host host (.mclk(mclk), .io_bus(io_bus), .cs_n(cs_n), .sck(sck),
        .host_val(host_val), .host_oe(host_oe));

    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // a released line floats: show a value that flips every cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_bus[i] = io_oe_ff[i] ? io_out_ff[i] : host_oe[i] ? host_val[i] : flt;
        end
    end

    always @(posedge mclk) begin
        flt    <= ~flt;
        cycles <= cycles + 1;
        if (rd_take_ff === 1'b1) rd_data <= rd_data + 8'h11;
        if (prog_vld_ff === 1'b1) progq.push_back(prog_byte_ff);
        if ((host_oe & io_oe_ff) !== 4'h0) check({28'h0, host_oe & io_oe_ff}, 32'h0);
        if (cycles == 30000) begin
            errors++;
            final_report();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report();
        $display("checked=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task quiet(input sfps_pkg::sfps_state_t st);
        @(negedge mclk);
        check({22'h0, io_out_ff, io_oe_ff, rd_take_ff, prog_vld_ff}, 32'h0);
        check(32'(state_ff), 32'(st));
    endtask

    function automatic int latv(input logic [1:0] code);
        latv = (code == 2'h0) ? 8 : (code == 2'h1) ? 6 : (code == 2'h2) ? 4 : 0;
    endfunction

    task run_row(input sfps_row_t r, input logic [1:0] code);
        logic [3:0]  s;
        logic [15:0] got;
        logic [39:0] hdr;
        int          mc;
        int          lat;
        mc  = (code == 2'h3) ? 0 : r.mode_clk;
        lat = r.has_lat ? latv(code) : 0;
        hdr = {r.op, 24'h5a3c96, 8'ha5};
        got = 16'h0;
        @(posedge mclk);
        cfg_latency_code <= code;
        cfg_quad_en      <= 1'b1;
        rd_data          <= 8'h3c;
        host.start();
        host.send(1, 8, {r.op, 32'h0});
        host.send(r.in_w, 24 / r.in_w, {hdr[31:8], 16'h0});
        host.send(r.in_w, mc, {hdr[7:0], 32'h0});
        @(negedge mclk);
        check(hdr_ff, (mc != 0) ? hdr[31:0] : hdr[39:8]);
        check(32'(state_ff), 32'(lat != 0 ? sfps_pkg::ST_LAT : r.st));
        for (int i = 0; i < lat; i++) begin
            // single reads keep si driven with junk, wider reads release io at once
            host.cyc(4'hd, (r.out_w == 1) ? 4'h1 : 4'h0, s);
            check({28'h0, io_oe_ff}, 32'h0);
        end
        check(hdr_ff, (mc != 0) ? hdr[31:0] : hdr[39:8]);
        for (int i = 0; i < 16 / r.out_w; i++) begin
            host.cyc(4'h0, 4'h0, s);
            got = (got << r.out_w) | 16'((r.out_w == 1) ? s[1] : (r.out_w == 2) ? s[1:0] : s);
            check({28'h0, io_oe_ff}, {28'h0, r.oe});
        end
        check({16'h0, got}, 32'h3c4d);
        host.stop();
        repeat (2) @(posedge mclk);
        quiet(sfps_pkg::ST_IDLE);
    endtask

    initial begin
        nrst             = 1'b0;
        flt              = 1'b0;
        cfg_latency_code = 2'h0;
        cfg_quad_en      = 1'b0;
        rd_data          = 8'h0;
        errors           = 0;
        samples_checked  = 0;
        cycles           = 0;
        rows[0] = '{`SFPS_OP_READ, 1, 0, 1, 1'b0, sfps_pkg::ST_SOUT, `SFPS_OE_SINGLE};
        rows[1] = '{`SFPS_OP_FAST, 1, 0, 1, 1'b1, sfps_pkg::ST_SOUT, `SFPS_OE_SINGLE};
        rows[2] = '{`SFPS_OP_DOR, 1, 0, 2, 1'b1, sfps_pkg::ST_DOUT, `SFPS_OE_DUAL};
        rows[3] = '{`SFPS_OP_QUAD_OUTPUT_READ, 1, 0, 4, 1'b1, sfps_pkg::ST_QOUT, `SFPS_OE_QUAD};
        rows[4] = '{`SFPS_OP_DIOR, 2, 4, 2, 1'b1, sfps_pkg::ST_DOUT, `SFPS_OE_DUAL};
        rows[5] = '{`SFPS_OP_QIOR, 4, 2, 4, 1'b1, sfps_pkg::ST_QOUT, `SFPS_OE_QUAD};
        repeat (20) @(posedge mclk);
        quiet(sfps_pkg::ST_IDLE);
        @(posedge mclk);
        nrst <= 1'b1;
        foreach (rows[k]) begin
            for (int c = 0; c < 4; c++) run_row(rows[k], 2'(c));
        end
        // ----------------------------------------------------------------
        // quad program, refused quad read, ddr inputs, abort, reset
        // ----------------------------------------------------------------
        host.start();
        host.send(1, 8, {`SFPS_OP_QUAD_PAGE_PROGRAM, 32'h0});
        host.send(1, 24, {24'h00ff00, 16'h0});
        host.send(4, 4, {16'hc3a5, 24'h0});
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check(32'(state_ff), 32'(sfps_pkg::ST_QIN));
        check({progq.size() == 2, progq[0], progq[1]}, {1'b1, 16'hc3a5});
        host.stop();
        @(posedge mclk);
        cfg_quad_en <= 1'b0;
        host.start();
        host.send(1, 8, {`SFPS_OP_QUAD_OUTPUT_READ, 32'h0});
        host.send(1, 24, 40'h0);
        quiet(sfps_pkg::ST_WAIT);
        host.stop();
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            cfg_latency_code <= 2'h0;
            cfg_quad_en      <= 1'b1;
            host.start();
            host.send(1, 8, {(k != 0) ? `SFPS_OP_DDRD : `SFPS_OP_DDRF, 32'h0});
            // the fall after the opcode is counted as the first data edge; the extra trailing edge lands in ST_DDRLAT
            host.ddr(k + 1, 1 + 32 / (k + 1), 32'h5a3c96a5);
            quiet(sfps_pkg::ST_DDRLAT);
            check(hdr_ff, 32'h5a3c96a5);
            host.stop();
        end
        host.start();
        host.send(1, 8, {`SFPS_OP_READ, 32'h0});
        host.send(1, 10, 40'h0);
        host.stop();
        repeat (2) @(posedge mclk);
        quiet(sfps_pkg::ST_IDLE);
        run_row(rows[0], 2'h0);
        host.start();
        host.send(1, 8, {`SFPS_OP_DOR, 32'h0});
        @(posedge mclk);
        nrst <= 1'b0;
        host.stop();
        quiet(sfps_pkg::ST_IDLE);
        @(posedge mclk);
        nrst <= 1'b1;
        run_row(rows[2], 2'h1);
        final_report();
    end
endmodule
